// [verilog/kbc_cfg.svh]
// Offsets, field positions, reset values and command codes of the host port.
`ifndef KBC_CFG_SVH
`define KBC_CFG_SVH
`define KBC_DATA_PORT 8'h60
`define KBC_CMD_PORT 8'h64
`define KBC_CFG_RAM_LOC 8'h20
`define KBC_CFG_RESET 8'h00
`define KBC_CFG_RSVD_MASK 8'h7f
`define ST_OBF 0
`define ST_IBF 1
`define ST_SYSF 2
`define ST_CMDF 3
`define ST_UNLOCK 4
`define ST_MOBF 5
`define ST_TMO 6
`define ST_PERR 7
`define CF_KIRQ 0
`define CF_MIRQ 1
`define CF_SYSF 2
`define CF_LOCKOVR 3
`define CF_KDIS 4
`define CF_MDIS 5
`define CF_XLATE 6
`define CMD_RD_CFG 8'h20
`define CMD_WR_CFG 8'h60
`define CMD_MSE_DIS 8'ha7
`define CMD_MSE_EN 8'ha8
`define CMD_SELFTEST 8'haa
`define CMD_KBD_DIS 8'had
`define CMD_KBD_EN 8'hae
`define CMD_WR_KOB 8'hd2
`define CMD_WR_MOB 8'hd3
`define RSP_SELFTEST_OK 8'h55
`define BREAK_PREFIX 8'hf0
`define BREAK_BIT 7
`endif

// [verilog/kbc_pkg.sv]
// Types shared by the keyboard and pointer host port.
package kbc_pkg;
  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_CFG_WR = 2'b01,
    EN_KOB_WR = 2'b10,
    EN_MOB_WR = 2'b11
  } engine_state_t;
endpackage

// [verilog/host_pair_buf.sv]
// Small FIFO between the serial receivers and the output buffer.
`timescale 1ns/1ns
module host_pair_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap naturally only for a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_depth
    $error("host_pair_buf needs DEPTH a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes: full and empty come straight from the occupancy count.
  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rd_ptr_r];

  // Storage is written only on an accepted push.
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// [verilog/scan_xlate.sv]
// Folds the break prefix of received scan codes into the legacy form.
`timescale 1ns/1ns
`include "kbc_cfg.svh"
module scan_xlate (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic take_in,
  input wire logic [7:0] code_in,
  output logic [7:0] code_out,
  output logic swallow_out
);
  logic brk_pend_r;

  // A prefix byte is eaten; the following code gets its release bit set.
  assign swallow_out = enable_in & (code_in == `BREAK_PREFIX);
  always_comb begin
    code_out = code_in;
    if (enable_in && brk_pend_r) begin
      code_out[`BREAK_BIT] = 1'b1;
    end
  end

  // Remembers a seen prefix until the next keyboard byte is taken.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      brk_pend_r <= 1'b0;
    end else if (take_in) begin
      brk_pend_r <= swallow_out;
    end
  end
endmodule

// [verilog/kbd_mouse_host_port.sv]
// Host-facing register port of the keyboard and pointer controller.
// Operation
// R1 - Status byte read at port 64H.
// R2 - Data at 60H, commands at 64H, one buffer.
// R3 - Status bit 3 marks command byte pending.
// R4 - Port 60H read returns output buffer.
// R5 - Status bit 1 input full, cleared when consumed.
// R6 - Status bit 0 output full, read clears.
// R7 - Status bit 5 marks pointer data.
// R8 - Status bit 7 keyboard parity error.
// R9 - Keyboard sends bytes with odd parity.
// R10 - Status bit 6 keyboard timeout.
// R11 - Status bit 4 low when locked; refuse codes.
// R12 - Status bit 2 mirrors system flag.
// R13 - Config byte lives at RAM 20H.
// R14 - Host writes config bit 7 as zero.
// R15 - Config bit 6 enables code translation.
// R16 - Config bit 5 disables pointer interface.
// R17 - Config bit 4 disables keyboard, clock low.
// R18 - Config bit 3 overrides lock switch.
// R19 - Config bit 1 enables pointer interrupt.
// R20 - Config bit 0 enables keyboard interrupt.
// R21 - Keyboard sends press, repeat, release codes.
// R22 - Commands at 64H, their data at 60H.
// R23 - Command 60H stores next data as config.
// R24 - Command 20H copies config to output.
// R25 - Output load sets full, pointer flag if mouse.
`timescale 1ns/1ns
`include "kbc_cfg.svh"
module kbd_mouse_host_port (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  input wire logic [7:0] kbd_byte_in,
  input wire logic kbd_parity_in,
  input wire logic kbd_valid_in,
  output logic kbd_ready_out,
  input wire logic kbd_timeout_in,
  input wire logic [7:0] mouse_byte_in,
  input wire logic mouse_valid_in,
  output logic mouse_ready_out,
  input wire logic lock_switch_input_in,
  output logic kbd_clock_line_out,
  output logic kbd_clock_line_oe_out,
  output logic keyboard_irq_line_out,
  output logic pointer_irq_line_out
);
  logic [7:0] cfg_r;
  logic [7:0] ib_r;
  logic ib_cmd_r;
  logic ibf_r;
  logic [7:0] ob_r;
  logic obf_r;
  logic ob_mouse_r;
  logic perr_r;
  logic tmo_r;
  logic lock_meta_r;
  logic lock_sync_r;
  logic reply_pend_r;
  logic [7:0] reply_r;
  logic reply_mouse_r;
  logic [7:0] rdata_r;
  kbc_pkg::engine_state_t st_r;
  logic [7:0] status;
  logic wr_data;
  logic wr_cmd;
  logic rd_status;
  logic rd_ob;
  logic take;
  logic locked;
  logic kbd_drop;
  logic kbd_push;
  logic mouse_push;
  logic kbd_good;
  logic kbd_perr;
  logic [9:0] buf_in;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [9:0] buf_out;
  logic buf_out_valid;
  logic buf_out_ready;
  logic buf_pop;
  logic [7:0] xcode;
  logic xswallow;
  logic load_reply;
  logic load_buf;

  // Port decode of host strobes.
  assign wr_data = io_wr_in & (io_addr_in == `KBC_DATA_PORT);
  assign wr_cmd = io_wr_in & (io_addr_in == `KBC_CMD_PORT);
  assign rd_status = io_rd_in & (io_addr_in == `KBC_CMD_PORT);
  assign rd_ob = io_rd_in & (io_addr_in == `KBC_DATA_PORT);

  // Lock switch is a pin, so it passes two flops first.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      lock_meta_r <= lock_switch_input_in;
      lock_sync_r <= lock_meta_r;
    end
  end

  // R18 lock override
  assign locked = lock_sync_r & ~cfg_r[`CF_LOCKOVR];

  // Status byte assembly, reserved positions none.
  always_comb begin
    status = 8'h00;
    status[`ST_OBF] = obf_r;
    status[`ST_IBF] = ibf_r;
    // R12 system flag mirror
    status[`ST_SYSF] = cfg_r[`CF_SYSF];
    status[`ST_CMDF] = ib_cmd_r;
    // R11 lock status
    status[`ST_UNLOCK] = ~locked;
    status[`ST_MOBF] = ob_mouse_r;
    status[`ST_TMO] = tmo_r;
    status[`ST_PERR] = perr_r;
  end

  // Read data is latched on the strobe and shown the next cycle.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
    end else if (rd_status) begin
      // R1 status read
      rdata_r <= status;
    end else if (rd_ob) begin
      // R4 output buffer read
      rdata_r <= ob_r;
    end
  end
  assign io_rdata_out = rdata_r;

  // R2 single input buffer
  // R3 command flag capture
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ib_r <= 8'h00;
      ib_cmd_r <= 1'b0;
    end else if (wr_data || wr_cmd) begin
      ib_r <= io_wdata_in;
      ib_cmd_r <= wr_cmd;
    end
  end

  // The engine consumes the input buffer once no reply is waiting.
  assign take = ibf_r & ~reply_pend_r;

  // R5 input full flag, a new write wins over consumption
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ibf_r <= 1'b0;
    end else if (wr_data || wr_cmd) begin
      ibf_r <= 1'b1;
    end else if (take) begin
      ibf_r <= 1'b0;
    end
  end

  // R22 command sequencer; a new command cancels a pending data phase.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_r <= kbc_pkg::EN_IDLE;
    end else if (take) begin
      if (ib_cmd_r) begin
        unique case (ib_r)
          // R23 wait for config data
          `CMD_WR_CFG: st_r <= kbc_pkg::EN_CFG_WR;
          `CMD_WR_KOB: st_r <= kbc_pkg::EN_KOB_WR;
          `CMD_WR_MOB: st_r <= kbc_pkg::EN_MOB_WR;
          default: st_r <= kbc_pkg::EN_IDLE;
        endcase
      end else begin
        st_r <= kbc_pkg::EN_IDLE;
      end
    end
  end

  // R13 config byte held in RAM location 20H
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cfg_r <= `KBC_CFG_RESET;
    end else if (take && ib_cmd_r) begin
      unique case (ib_r)
        // R16 pointer disable commands
        `CMD_MSE_DIS: cfg_r[`CF_MDIS] <= 1'b1;
        `CMD_MSE_EN: cfg_r[`CF_MDIS] <= 1'b0;
        // R17 keyboard disable commands
        `CMD_KBD_DIS: cfg_r[`CF_KDIS] <= 1'b1;
        `CMD_KBD_EN: cfg_r[`CF_KDIS] <= 1'b0;
        default: cfg_r <= cfg_r;
      endcase
    end else if (take && st_r == kbc_pkg::EN_CFG_WR) begin
      // R23 store config; R14 reserved top bit kept zero
      cfg_r <= ib_r & `KBC_CFG_RSVD_MASK;
    end
  end

  // Replies from the command engine wait here for a free output buffer.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      reply_pend_r <= 1'b0;
      reply_r <= 8'h00;
      reply_mouse_r <= 1'b0;
    end else if (take && ib_cmd_r && ib_r == `CMD_RD_CFG) begin
      // R24 config byte reply
      reply_pend_r <= 1'b1;
      reply_r <= cfg_r;
      reply_mouse_r <= 1'b0;
    end else if (take && ib_cmd_r && ib_r == `CMD_SELFTEST) begin
      reply_pend_r <= 1'b1;
      reply_r <= `RSP_SELFTEST_OK;
      reply_mouse_r <= 1'b0;
    end else if (take && !ib_cmd_r && st_r == kbc_pkg::EN_KOB_WR) begin
      reply_pend_r <= 1'b1;
      reply_r <= ib_r;
      reply_mouse_r <= 1'b0;
    end else if (take && !ib_cmd_r && st_r == kbc_pkg::EN_MOB_WR) begin
      reply_pend_r <= 1'b1;
      reply_r <= ib_r;
      reply_mouse_r <= 1'b1;
    end else if (load_reply) begin
      reply_pend_r <= 1'b0;
    end
  end

  // R11 refuse codes when locked; R17 nothing received when disabled
  assign kbd_drop = cfg_r[`CF_KDIS] | locked;
  assign kbd_push = kbd_valid_in & ~kbd_drop;
  // R16 pointer bytes discarded while disabled
  assign mouse_push = mouse_valid_in & ~cfg_r[`CF_MDIS] & ~kbd_push;
  assign kbd_ready_out = kbd_drop | buf_in_ready;
  assign mouse_ready_out = cfg_r[`CF_MDIS] | (buf_in_ready & ~kbd_push);
  assign buf_in_valid = kbd_push | mouse_push;
  // R9 odd parity expected from the keyboard
  assign kbd_perr = ~(^{kbd_byte_in, kbd_parity_in});
  assign buf_in = kbd_push ? {1'b0, kbd_perr, kbd_byte_in} : {1'b1, 1'b0, mouse_byte_in};
  assign kbd_good = kbd_push & buf_in_ready;

  // R17 keyboard clock held low while disabled
  assign kbd_clock_line_out = 1'b0;
  assign kbd_clock_line_oe_out = cfg_r[`CF_KDIS];

  // R8 parity flag; R10 timeout flag, a new timeout wins over a good byte
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      perr_r <= 1'b0;
      tmo_r <= 1'b0;
    end else begin
      if (kbd_good) begin
        perr_r <= kbd_perr;
      end
      if (kbd_timeout_in) begin
        tmo_r <= 1'b1;
      end else if (kbd_good) begin
        tmo_r <= 1'b0;
      end
    end
  end

  host_pair_buf #(
    .W(10),
    .DEPTH(2)
  ) u_rx_buf (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .in_data_in(buf_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .out_data_out(buf_out),
    .out_valid_out(buf_out_valid),
    .out_ready_in(buf_out_ready)
  );

  // R15 translation only for keyboard bytes
  scan_xlate u_xlate (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .enable_in(cfg_r[`CF_XLATE] & ~buf_out[9]),
    .take_in(buf_pop & ~buf_out[9]),
    .code_in(buf_out[7:0]),
    .code_out(xcode),
    .swallow_out(xswallow)
  );

  // Replies take the output buffer ahead of received bytes.
  assign load_reply = reply_pend_r & ~obf_r;
  assign buf_out_ready = ~obf_r & ~reply_pend_r;
  assign buf_pop = buf_out_valid & buf_out_ready;
  assign load_buf = buf_pop & ~xswallow;

  // R25 loading sets full; a load wins over a host read
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ob_r <= 8'h00;
      obf_r <= 1'b0;
      ob_mouse_r <= 1'b0;
    end else if (load_reply) begin
      ob_r <= reply_r;
      obf_r <= 1'b1;
      ob_mouse_r <= reply_mouse_r;
    end else if (load_buf) begin
      ob_r <= xcode;
      obf_r <= 1'b1;
      // R7 pointer data flag
      ob_mouse_r <= buf_out[9];
    end else if (rd_ob) begin
      // R6 read clears full
      obf_r <= 1'b0;
      ob_mouse_r <= 1'b0;
    end
  end

  // R19 pointer interrupt; R20 keyboard interrupt
  assign keyboard_irq_line_out = obf_r & ~ob_mouse_r & cfg_r[`CF_KIRQ];
  assign pointer_irq_line_out = obf_r & ob_mouse_r & cfg_r[`CF_MIRQ];

  property p_status_read;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      rd_status |=> io_rdata_out == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // R1

  property p_cmd_flag;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      io_wr_in && io_addr_in == `KBC_CMD_PORT |=> ib_cmd_r && ibf_r;
  endproperty
  a_cmd_flag: assert property (p_cmd_flag) else $error("command flag not set"); // R3

  property p_data_flag;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      io_wr_in && io_addr_in == `KBC_DATA_PORT |=> !ib_cmd_r ##0 ib_r == $past(io_wdata_in);
  endproperty
  a_data_flag: assert property (p_data_flag) else $error("data write not buffered"); // R2

  property p_ob_read;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      rd_ob && !load_reply && !load_buf |=> !obf_r ##0 io_rdata_out == $past(ob_r);
  endproperty
  a_ob_read: assert property (p_ob_read) else $error("output read wrong"); // R6

  property p_ibf_take;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      take && !io_wr_in |=> !ibf_r;
  endproperty
  a_ibf_take: assert property (p_ibf_take) else $error("input full not cleared"); // R5

  property p_sysflag;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      take && st_r == kbc_pkg::EN_CFG_WR && !ib_cmd_r
      |=> status[`ST_SYSF] == $past(ib_r[`CF_SYSF]) && !cfg_r[7];
  endproperty
  a_sysflag: assert property (p_sysflag) else $error("config write lost"); // R23

  property p_rd_cfg;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      take && ib_cmd_r && ib_r == `CMD_RD_CFG && !obf_r && !load_buf
      |=> ##1 obf_r && ob_r == $past(cfg_r, 2) && !ob_mouse_r;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config reply wrong"); // R24

  property p_kbd_irq;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      load_buf && !buf_out[9] && cfg_r[`CF_KIRQ] && !take
      |=> keyboard_irq_line_out && !pointer_irq_line_out;
  endproperty
  a_kbd_irq: assert property (p_kbd_irq) else $error("keyboard irq wrong"); // R20

  property p_lock;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      lock_sync_r && !cfg_r[`CF_LOCKOVR] |-> !status[`ST_UNLOCK] && !kbd_push;
  endproperty
  a_lock: assert property (p_lock) else $error("locked codes accepted"); // R11

  property p_kdis;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      cfg_r[`CF_KDIS] |-> kbd_clock_line_oe_out && !kbd_clock_line_out && !kbd_push;
  endproperty
  a_kdis: assert property (p_kdis) else $error("keyboard not held off"); // R17

  property p_parity;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      kbd_good |=> perr_r == !$past(^{kbd_byte_in, kbd_parity_in});
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong"); // R8
endmodule

// [sim/kbc_host_model.sv]
// Host processor model issuing I/O reads and writes to the port.
`timescale 1ns/1ns
module kbc_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] io_rdata_in,
  output logic [7:0] io_addr_out,
  output logic io_rd_out,
  output logic io_wr_out,
  output logic [7:0] io_wdata_out
);
  logic [7:0] addr_r = 8'h00;
  logic [7:0] data_r = 8'h00;
  logic last_wr_r = 1'b0;
  time end_t = 0;
  // Address shows a changed pattern while no strobe is up, data while no write strobe is up.
  assign io_addr_out = (io_rd_out | io_wr_out) ? addr_r : ~addr_r;
  assign io_wdata_out = io_wr_out ? data_r : ~data_r;
  initial begin
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
  end
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    if (end_t == $time && last_wr_r == wr) begin
      @(posedge ref_clk_in);
      #1;
    end
    addr_r = a;
    data_r = d;
    if (wr) begin
      io_wr_out = 1'b1;
    end else begin
      io_rd_out = 1'b1;
    end
    @(posedge ref_clk_in);
    #1;
    if (wr) begin
      io_wr_out = 1'b0;
    end else begin
      io_rd_out = 1'b0;
    end
    q = io_rdata_in;
    end_t = $time;
    last_wr_r = wr;
  endtask
endmodule

// [sim/kbd_mouse_host_port_bench.sv]
// Self-checking bench of the keyboard and pointer host port.
`timescale 1ns/1ns
`include "kbc_cfg.svh"
module kbd_mouse_host_port_bench;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] io_addr, io_wdata, io_rdata, kbd_byte, mouse_byte, q, v;
  logic io_rd, io_wr, kbd_par, kbd_valid, kbd_ready, kbd_tmo;
  logic mouse_valid, mouse_ready, lock, clk_line, clk_oe, kirq, mirq;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  time vld_t = 0;
  integer seed = 38;
  logic [7:0] b [4];
  logic [7:0] cmds [4] = '{`CMD_MSE_DIS, `CMD_MSE_EN, `CMD_KBD_DIS, `CMD_KBD_EN};
  logic [7:0] cfgs [4] = '{8'h20, 8'h00, 8'h10, 8'h00};

  kbd_mouse_host_port i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .io_addr_in(io_addr), .io_rd_in(io_rd), .io_wr_in(io_wr), .io_wdata_in(io_wdata),
    .io_rdata_out(io_rdata), .kbd_byte_in(kbd_byte), .kbd_parity_in(kbd_par),
    .kbd_valid_in(kbd_valid), .kbd_ready_out(kbd_ready), .kbd_timeout_in(kbd_tmo),
    .mouse_byte_in(mouse_byte), .mouse_valid_in(mouse_valid),
    .mouse_ready_out(mouse_ready), .lock_switch_input_in(lock),
    .kbd_clock_line_out(clk_line), .kbd_clock_line_oe_out(clk_oe),
    .keyboard_irq_line_out(kirq), .pointer_irq_line_out(mirq));

  kbc_host_model i_host (.ref_clk_in(ref_clk_in), .io_rdata_in(io_rdata),
    .io_addr_out(io_addr), .io_rd_out(io_rd), .io_wr_out(io_wr), .io_wdata_out(io_wdata));

  // Clock of 100 ns period.
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // Cuts a hung run short.
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic odd_par(input logic [7:0] d);
    return ~^d;
  endfunction

  // Expected status for a full output buffer.
  function automatic logic [7:0] st_exp(input logic perr, input logic mse);
    return {perr, 1'b0, mse, 5'h01};
  endfunction

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_host.access(1'b0, a, 8'h00, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.access(1'b1, a, d, x);
  endtask

  task automatic cfg_wr(input logic [7:0] d);
    logic [7:0] x;
    wr(`KBC_CMD_PORT, `CMD_WR_CFG);
    wr(`KBC_DATA_PORT, d & 8'h7f);
    rd(`KBC_CMD_PORT, x);
    rd(`KBC_CMD_PORT, x);
  endtask

  task automatic wait_obf();
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h00;
    while (s[0] !== 1'b1 && n < 20) begin
      rd(`KBC_CMD_PORT, s);
      n++;
    end
  endtask

  task automatic cfg_rd(output logic [7:0] d);
    wr(`KBC_CMD_PORT, `CMD_RD_CFG);
    wait_obf();
    rd(`KBC_DATA_PORT, d);
  endtask

  // Offers one received byte and holds it until taken.
  task automatic send(input logic mse, input logic [7:0] d, input logic p);
    int n;
    if (vld_t == $time) begin
      @(posedge ref_clk_in);
      #1;
    end
    if (mse) begin
      mouse_byte = d;
      mouse_valid = 1'b1;
    end else begin
      kbd_byte = d;
      kbd_par = p;
      kbd_valid = 1'b1;
    end
    #1;
    n = 0;
    while (!(mse ? mouse_ready : kbd_ready) && n < 50) begin
      @(posedge ref_clk_in);
      #2;
      n++;
    end
    @(posedge ref_clk_in);
    #1;
    mouse_valid = 1'b0;
    kbd_valid = 1'b0;
    vld_t = $time;
  endtask

  // Main sequence.
  initial begin
    kbd_byte = 8'h00;
    kbd_par = 1'b0;
    kbd_valid = 1'b0;
    kbd_tmo = 1'b0;
    mouse_byte = 8'h00;
    mouse_valid = 1'b0;
    lock = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    rd(`KBC_CMD_PORT, q);
    chk8(q, 8'h10);
    wr(`KBC_DATA_PORT, 8'h5a);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h0a, 8'h02);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h02, 8'h00);
    wr(`KBC_CMD_PORT, `CMD_SELFTEST);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h0a, 8'h0a);
    wait_obf();
    rd(`KBC_DATA_PORT, q);
    chk8(q, `RSP_SELFTEST_OK);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h01, 8'h00);
    // Unmapped places are ignored.
    wr(8'h61, 8'h33);
    rd(8'h70, v);
    chk8(v, q);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      cfg_wr(v);
      cfg_rd(q);
      chk8(q, v & 8'h7f);
      rd(`KBC_CMD_PORT, q);
      chk8(q & 8'h04, v & 8'h04);
      chk1(clk_oe, v[4]);
      chk1(clk_line, 1'b0);
      cfg_wr(8'h00);
      wr(`KBC_CMD_PORT, cmds[i]);
      cfg_rd(q);
      chk8(q, cfgs[i]);
      chk1(clk_oe, cfgs[i][4]);
    end
    // Keyboard and pointer bytes, one with bad parity.
    cfg_wr(8'h03);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      send(i[0], v, odd_par(v) ^ (i == 2));
      wait_obf();
      chk1(i[0] ? mirq : kirq, 1'b1);
      chk1(i[0] ? kirq : mirq, 1'b0);
      rd(`KBC_CMD_PORT, q);
      chk8(q & 8'ha1, st_exp(i >= 2, i[0]));
      rd(`KBC_DATA_PORT, q);
      chk8(q, v);
      chk1(kirq | mirq, 1'b0);
    end
    // Pointer disabled drops its bytes.
    cfg_wr(8'h22);
    send(1'b1, 8'h77, 1'b0);
    rd(`KBC_CMD_PORT, q);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h01, 8'h00);
    kbd_tmo = 1'b1;
    @(posedge ref_clk_in);
    #1;
    kbd_tmo = 1'b0;
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h40, 8'h40);
    // Lock switch and its override.
    lock = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h10, 8'h00);
    send(1'b0, 8'h12, odd_par(8'h12));
    rd(`KBC_CMD_PORT, q);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h01, 8'h00);
    cfg_wr(8'h08);
    rd(`KBC_CMD_PORT, q);
    chk8(q & 8'h10, 8'h10);
    lock = 1'b0;
    // Break prefix folding.
    cfg_wr(8'h40);
    v = 8'($random(seed)) & 8'h7f;
    send(1'b0, v, odd_par(v));
    wait_obf();
    rd(`KBC_DATA_PORT, q);
    chk8(q, v);
    send(1'b0, `BREAK_PREFIX, odd_par(`BREAK_PREFIX));
    send(1'b0, v, odd_par(v));
    wait_obf();
    rd(`KBC_DATA_PORT, q);
    chk8(q, v | 8'h80);
    // Fill the buffer while the host stalls, then drain it.
    cfg_wr(8'h00);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($random(seed));
    end
    for (int i = 0; i < 3; i++) begin
      send(1'b0, b[i], odd_par(b[i]));
    end
    fork
      send(1'b0, b[3], odd_par(b[3]));
      begin
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk1(kbd_ready, 1'b0);
        chk1(mouse_ready, 1'b0);
        rd(`KBC_DATA_PORT, q);
        chk8(q, b[0]);
      end
    join
    for (int i = 1; i < 4; i++) begin
      wait_obf();
      rd(`KBC_DATA_PORT, q);
      chk8(q, b[i]);
    end
    // Host-written keyboard and pointer output bytes.
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      wr(`KBC_CMD_PORT, i[0] ? `CMD_WR_MOB : `CMD_WR_KOB);
      wr(`KBC_DATA_PORT, v);
      wait_obf();
      chk1(kirq | mirq, 1'b0);
      rd(`KBC_CMD_PORT, q);
      chk8(q & 8'h21, {2'b00, i[0], 5'h01});
      rd(`KBC_DATA_PORT, q);
      chk8(q, v);
    end
    test_done();
  end
endmodule
